// ---- common/rbi_pkg.sv ----
package rbi_pkg;
   // fixed plant sizes
   localparam int NROD = 64;
   localparam int POSW = 16;
   localparam int NSCB = 10;
   // register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_INOP_LO = 8'h10;
   localparam logic [7:0] A_INOP_HI = 8'h14;
   localparam logic [7:0] A_ACT_LO = 8'h18;
   localparam logic [7:0] A_ACT_HI = 8'h1C;
   localparam logic [7:0] A_OVR_LO = 8'h20;
   localparam logic [7:0] A_OVR_HI = 8'h24;
   localparam logic [7:0] A_RESA_LO = 8'h28;
   localparam logic [7:0] A_RESA_HI = 8'h2C;
   localparam logic [7:0] A_RESB_LO = 8'h30;
   localparam logic [7:0] A_RESB_HI = 8'h34;
   localparam logic [7:0] A_SUB_LO = 8'h38;
   localparam logic [7:0] A_SUB_HI = 8'h3C;
   localparam logic [7:0] A_SCB = 8'h40;
   // count limits
   localparam logic [6:0] INOP_MAX_RUN = 7'h08;
   localparam logic [6:0] INOP_MAX_REFUEL = 7'h36;
   localparam logic [1:0] OVR_MAX = 2'h2;
   // last command result codes
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_OK = 2'h1;
   localparam logic [1:0] RES_REJ = 2'h2;
   // rod movement modes, gray along manual-semi-auto
   typedef enum logic [1:0] {
      MD_MANUAL = 2'h0,
      MD_SEMI = 2'h1,
      MD_AUTO = 2'h3
   } rbi_mode_t;
   // console bypass commands
   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_INOP_SET = 4'h1, OP_INOP_CLR = 4'h2,
      OP_ACTIVATE = 4'h3, OP_SUBST = 4'h4, OP_SUBST_CLR = 4'h5,
      OP_RESA = 4'h6, OP_RESB = 4'h7, OP_RES_CLR = 4'h8,
      OP_OVR_SET = 4'h9, OP_OVR_CLR = 4'hA, OP_SCB_SET = 4'hB,
      OP_SCB_CLR = 4'hC
   } rbi_op_t;
   // command word as written to A_CMD
   typedef struct packed {
      logic [15:0] value;
      logic [5:0] rsvd;
      logic [5:0] rod;
      rbi_op_t op;
   } rbi_cmd_t;
   // position lookup from the drive control
   typedef struct packed {
      logic [5:0] rod;
      logic [15:0] pos_a;
      logic [15:0] pos_b;
   } rbi_pos_req_t;
endpackage

// ---- design/rbi_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module rbi_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin side and core side
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ---- design/rbi_top.sv ----
// Summary of operation
// - one resolver bypassed: other resolver feeds both channels
// - refuse bypassing both resolvers of one drive
// - outside refuel, at most eight inoperable rods
// - in refuel, at most 54 inoperable rods
// - activate inoperable set only in manual mode with permissive
// - substituted position replaces measured one on both channels
// - inoperable rod gets no motor power and no brake power
// - inoperable rods ignore normal and special insertion commands
// - override rods excluded from sequence compliance checks
// - override rods accept manual movement only
// - at most two override rods, same hydraulic unit
// - override leaves special insertions and rod blocks untouched
// - after scram test, follow-up insertion is commanded automatically for override rods
// - refuse channel bypass when partner channel already bypassed
// - channel bypasses never stop special insertion functions
// - channel bypass for A or B of five subsystems
// - report status and extent of every bypass
// - report substitution status to both operator interfaces
// - a rod block on a channel with no channel bypass forces automatic mode back to manual
// - blocks follow their pins and are not latched; channel bypass masks that channel
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rbi_top (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // plant pins, asynchronous
   input wire logic REFUEL_MODE,
   input wire logic BYP_PERMIT,
   input wire logic ROD_BLOCK_A,
   input wire logic ROD_BLOCK_B,
   input wire logic ALT_ROD_INSERT,
   input wire logic SEL_ROD_RUNIN,
   input wire logic SCRAM_FOLLOW,
   input wire logic DPS_RUNIN,
   input wire logic SCRAM_TEST_DONE,
   // drive control, same clock
   input wire logic [63:0] MAN_MOVE_REQ,
   input wire logic [63:0] SEQ_MOVE_REQ,
   input wire rbi_pkg::rbi_pos_req_t POS_REQ,
   // drive outputs
   output logic [63:0] MOTOR_EN,
   output logic [63:0] BRAKE_EN,
   output logic [63:0] FOLLOW_INS,
   output logic [63:0] SEQ_CHECK_EN,
   output logic [15:0] POS_CH_A,
   output logic [15:0] POS_CH_B,
   // operator and position unit status
   output logic [63:0] INOP_TO_PIU,
   output logic [63:0] SUBST_MAIN,
   output logic [63:0] SUBST_PIU,
   output logic [9:0] SCB_STATE,
   output logic [1:0] MODE
);
   logic [8:0] pins_s;
   logic refuel_s, permit_s, blk_a_s, blk_b_s, ari_s, runin_s;
   logic follow_s, dps_s, tdone_s, tdone_d_r;
   logic ap_wr_r, cmd_go_r;
   logic [7:0] ap_addr_r;
   rbi_pkg::rbi_cmd_t cmd_r;
   rbi_pkg::rbi_mode_t mode_r, mode_nxt;
   logic [63:0] inop_r, act_r, ovr_r, resa_r, resb_r, sub_r;
   logic [63:0] inop_nxt, ovr_nxt, resa_nxt, resb_nxt, sub_nxt;
   logic [9:0] scb_r, scb_nxt;
   logic [6:0] inop_cnt_r, inop_cnt_nxt;
   logic [1:0] ovr_cnt_r, ovr_cnt_nxt, res_r, res_nxt;
   logic [15:0] sub_pos [0:63];
   logic [63:0] sub_eff;

   // all plant pins through two flops before use
   rbi_sync #(.W(9)) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .d({REFUEL_MODE, BYP_PERMIT, ROD_BLOCK_A, ROD_BLOCK_B,
          ALT_ROD_INSERT, SEL_ROD_RUNIN, SCRAM_FOLLOW, DPS_RUNIN,
          SCRAM_TEST_DONE}),
      .q(pins_s)
   );
   assign {refuel_s, permit_s, blk_a_s, blk_b_s, ari_s, runin_s,
           follow_s, dps_s, tdone_s} = pins_s;

   // bus address phase decode
   wire ap_take = HSEL & HREADY & HTRANS[1];
   wire in_rng = (HADDR[31:8] == 24'h0000_00);
   wire [7:0] ra = HADDR[7:0];
   wire wr_ctrl = ap_wr_r & (ap_addr_r == rbi_pkg::A_CTRL);
   wire wr_cmd = ap_wr_r & (ap_addr_r == rbi_pkg::A_CMD);

   // block state; a channel bypass masks its own channel's blocks
   wire scb_any_a = scb_r[0] | scb_r[2] | scb_r[4] | scb_r[6] | scb_r[8];
   wire scb_any_b = scb_r[1] | scb_r[3] | scb_r[5] | scb_r[7] | scb_r[9];
   wire blk_eff = (blk_a_s & ~scb_any_a) |
                  (blk_b_s & ~scb_any_b);
   // special insertions ignore override and channel bypasses
   wire spec_any = ari_s | runin_s |
                   follow_s | dps_s;
   wire tdone_p = tdone_s & ~tdone_d_r;

   // status word readable by software
   wire [31:0] stat_w = {11'h000, permit_s, refuel_s, blk_eff, mode_r,
                         2'h0, ovr_cnt_r, 1'b0, inop_cnt_r, 2'h0, res_r};

   // register read select, zero for unmapped
   wire [31:0] rd_mux =
      !in_rng ? 32'h0000_0000 :
      (ra == rbi_pkg::A_CTRL) ? {30'h0000_0000, mode_r} :
      (ra == rbi_pkg::A_STAT) ? stat_w :
      (ra == rbi_pkg::A_INOP_LO) ? inop_r[31:0] :
      (ra == rbi_pkg::A_INOP_HI) ? inop_r[63:32] :
      (ra == rbi_pkg::A_ACT_LO) ? act_r[31:0] :
      (ra == rbi_pkg::A_ACT_HI) ? act_r[63:32] :
      (ra == rbi_pkg::A_OVR_LO) ? ovr_r[31:0] :
      (ra == rbi_pkg::A_OVR_HI) ? ovr_r[63:32] :
      (ra == rbi_pkg::A_RESA_LO) ? resa_r[31:0] :
      (ra == rbi_pkg::A_RESA_HI) ? resa_r[63:32] :
      (ra == rbi_pkg::A_RESB_LO) ? resb_r[31:0] :
      (ra == rbi_pkg::A_RESB_HI) ? resb_r[63:32] :
      (ra == rbi_pkg::A_SUB_LO) ? sub_eff[31:0] :
      (ra == rbi_pkg::A_SUB_HI) ? sub_eff[63:32] :
      (ra == rbi_pkg::A_SCB) ? {22'h00_0000, scb_r} : 32'h0000_0000;

   // bus phase registers; answers with no wait state, always okay
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ap_wr_r <= 1'b0;
         ap_addr_r <= 8'h00;
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         ap_wr_r <= ap_take & HWRITE & in_rng;
         ap_addr_r <= ra;
         HRDATA <= (ap_take & ~HWRITE) ? rd_mux : 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // commands run one cycle after their data phase
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         cmd_go_r <= 1'b0;
         cmd_r <= '0;
      end else begin
         cmd_go_r <= wr_cmd;
         cmd_r <= wr_cmd ? HWDATA : cmd_r;
      end
   end

   // request checks against permissives and limits
   wire [5:0] rd = cmd_r.rod;
   wire [5:0] rd_ev = {rd[5:1], 1'b0};
   wire [5:0] rd_od = {rd[5:1], 1'b1};
   wire [3:0] sx = rd[3:0];
   wire [3:0] sx_mate = {sx[3:1], ~sx[0]};
   wire [6:0] inop_lim = refuel_s ? rbi_pkg::INOP_MAX_REFUEL
                                  : rbi_pkg::INOP_MAX_RUN;
   wire inop_ok = inop_r[rd] | (inop_cnt_r < inop_lim);
   wire pair_has = ovr_r[rd_ev] | ovr_r[rd_od];
   wire ovr_ok = ovr_r[rd] | (ovr_cnt_r == 2'h0) |
                 ((ovr_cnt_r < rbi_pkg::OVR_MAX) & pair_has);
   wire act_ok = (mode_r == rbi_pkg::MD_MANUAL) & permit_s;
   wire scb_ok = (sx < 4'(rbi_pkg::NSCB)) &
                 ~scb_r[sx_mate];
   wire scb_idx_ok = sx < 4'(rbi_pkg::NSCB);

   // next bypass state from the pending command
   always_comb begin
      inop_nxt = inop_r;
      ovr_nxt = ovr_r;
      resa_nxt = resa_r;
      resb_nxt = resb_r;
      sub_nxt = sub_r;
      scb_nxt = scb_r;
      inop_cnt_nxt = inop_cnt_r;
      ovr_cnt_nxt = ovr_cnt_r;
      res_nxt = rbi_pkg::RES_REJ;
      case (cmd_r.op)
         rbi_pkg::OP_INOP_SET: begin
            if (inop_ok) begin
               res_nxt = rbi_pkg::RES_OK;
               inop_nxt[rd] = 1'b1;
               inop_cnt_nxt = inop_cnt_r + 7'(!inop_r[rd]);
            end
         end
         rbi_pkg::OP_INOP_CLR: begin
            res_nxt = rbi_pkg::RES_OK;
            inop_nxt[rd] = 1'b0;
            sub_nxt[rd] = 1'b0;
            inop_cnt_nxt = inop_cnt_r - 7'(inop_r[rd]);
         end
         rbi_pkg::OP_ACTIVATE: begin
            if (act_ok) begin
               res_nxt = rbi_pkg::RES_OK;
            end
         end
         rbi_pkg::OP_SUBST: begin
            if (inop_r[rd]) begin
               res_nxt = rbi_pkg::RES_OK;
               sub_nxt[rd] = 1'b1;
            end
         end
         rbi_pkg::OP_SUBST_CLR: begin
            res_nxt = rbi_pkg::RES_OK;
            sub_nxt[rd] = 1'b0;
         end
         rbi_pkg::OP_RESA: begin
            if (!resb_r[rd]) begin
               res_nxt = rbi_pkg::RES_OK;
               resa_nxt[rd] = 1'b1;
            end
         end
         rbi_pkg::OP_RESB: begin
            if (!resa_r[rd]) begin
               res_nxt = rbi_pkg::RES_OK;
               resb_nxt[rd] = 1'b1;
            end
         end
         rbi_pkg::OP_RES_CLR: begin
            res_nxt = rbi_pkg::RES_OK;
            resa_nxt[rd] = 1'b0;
            resb_nxt[rd] = 1'b0;
         end
         rbi_pkg::OP_OVR_SET: begin
            if (ovr_ok) begin
               res_nxt = rbi_pkg::RES_OK;
               ovr_nxt[rd] = 1'b1;
               ovr_cnt_nxt = ovr_cnt_r + 2'(!ovr_r[rd]);
            end
         end
         rbi_pkg::OP_OVR_CLR: begin
            res_nxt = rbi_pkg::RES_OK;
            ovr_nxt[rd] = 1'b0;
            ovr_cnt_nxt = ovr_cnt_r - 2'(ovr_r[rd]);
         end
         rbi_pkg::OP_SCB_SET: begin
            if (scb_ok) begin
               res_nxt = rbi_pkg::RES_OK;
               scb_nxt[sx] = 1'b1;
            end
         end
         rbi_pkg::OP_SCB_CLR: begin
            if (scb_idx_ok) begin
               res_nxt = rbi_pkg::RES_OK;
               scb_nxt[sx] = 1'b0;
            end
         end
         default: begin
            res_nxt = rbi_pkg::RES_REJ;
         end
      endcase
   end

   wire do_act = cmd_go_r & (cmd_r.op == rbi_pkg::OP_ACTIVATE) & act_ok;
   wire do_sub = cmd_go_r & (cmd_r.op == rbi_pkg::OP_SUBST) & inop_r[rd];

   // bypass state registers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         inop_r <= '0;
         act_r <= '0;
         ovr_r <= '0;
         resa_r <= '0;
         resb_r <= '0;
         sub_r <= '0;
         scb_r <= '0;
         inop_cnt_r <= 7'h00;
         ovr_cnt_r <= 2'h0;
         res_r <= rbi_pkg::RES_NONE;
      end else if (cmd_go_r) begin
         inop_r <= inop_nxt;
         act_r <= do_act ? inop_r : act_r;
         ovr_r <= ovr_nxt;
         resa_r <= resa_nxt;
         resb_r <= resb_nxt;
         sub_r <= sub_nxt;
         scb_r <= scb_nxt;
         inop_cnt_r <= inop_cnt_nxt;
         ovr_cnt_r <= ovr_cnt_nxt;
         res_r <= res_nxt;
      end
   end

   // operator substitute positions, one word per rod
   always_ff @(posedge CORE_CLK) begin
      if (do_sub) begin
         sub_pos[rd] <= cmd_r.value;
      end
   end

   // mode: a rod block drops automatic to manual
   always_comb begin
      mode_nxt = mode_r;
      if (wr_ctrl) begin
         case (HWDATA[1:0])
            2'h1: mode_nxt = rbi_pkg::MD_SEMI;
            2'h3: mode_nxt = rbi_pkg::MD_AUTO;
            default: mode_nxt = rbi_pkg::MD_MANUAL;
         endcase
      end
      if (blk_eff && mode_nxt == rbi_pkg::MD_AUTO) begin
         mode_nxt = rbi_pkg::MD_MANUAL;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         mode_r <= rbi_pkg::MD_MANUAL;
         tdone_d_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         tdone_d_r <= tdone_s;
      end
   end

   // substitution only counts while the rod is actively bypassed
   assign sub_eff = sub_r & act_r;
   wire man_ok = (mode_r == rbi_pkg::MD_MANUAL) & ~blk_eff;
   wire seq_ok = (mode_r != rbi_pkg::MD_MANUAL) & ~blk_eff;

   // per-rod drive gating
   for (genvar i = 0; i < rbi_pkg::NROD; i++) begin : g_rod
      logic fol_r;
      wire move = (MAN_MOVE_REQ[i] & man_ok) |
                  (SEQ_MOVE_REQ[i] & seq_ok & ~ovr_r[i]) |
                  spec_any | fol_r;
      wire run = move & ~act_r[i];
      always_ff @(posedge CORE_CLK) begin
         if (RST) begin
            fol_r <= 1'b0;
            MOTOR_EN[i] <= 1'b0;
            BRAKE_EN[i] <= 1'b0;
            SEQ_CHECK_EN[i] <= 1'b1;
         end else begin
            // override clear wins over test-done set
            fol_r <= (tdone_p | fol_r) & ovr_r[i];
            MOTOR_EN[i] <= run;
            BRAKE_EN[i] <= run;
            SEQ_CHECK_EN[i] <= ~ovr_r[i];
         end
      end
      assign FOLLOW_INS[i] = fol_r;
   end

   // position to both channels; substitute beats resolver bypass
   wire [5:0] pr = POS_REQ.rod;
   wire [15:0] pa = sub_eff[pr] ? sub_pos[pr] :
                    resa_r[pr] ? POS_REQ.pos_b : POS_REQ.pos_a;
   wire [15:0] pb = sub_eff[pr] ? sub_pos[pr] :
                    resb_r[pr] ? POS_REQ.pos_a : POS_REQ.pos_b;

   // registered outputs toward drives and operator interfaces
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         POS_CH_A <= 16'h0000;
         POS_CH_B <= 16'h0000;
         INOP_TO_PIU <= '0;
         SUBST_MAIN <= '0;
         SUBST_PIU <= '0;
         SCB_STATE <= 10'h000;
         MODE <= rbi_pkg::MD_MANUAL;
      end else begin
         POS_CH_A <= pa;
         POS_CH_B <= pb;
         INOP_TO_PIU <= act_r;
         SUBST_MAIN <= sub_eff;
         SUBST_PIU <= sub_eff;
         SCB_STATE <= scb_r;
         MODE <= mode_r;
      end
   end

   // checks
   sequence s_full_run;
      cmd_go_r && cmd_r.op == rbi_pkg::OP_INOP_SET && !inop_r[rd]
      && !refuel_s && inop_cnt_r == 7'h08;
   endsequence
   sequence s_refused;
      res_r == rbi_pkg::RES_REJ && inop_cnt_r == 7'h08;
   endsequence
   property p_res_two;
      @(posedge CORE_CLK) disable iff (RST) (resa_r & resb_r) == '0;
   endproperty
   a_res_two: assert property (p_res_two)
      else $error("both resolvers out");
   property p_inop_eight;
      @(posedge CORE_CLK) disable iff (RST) s_full_run |=> s_refused;
   endproperty
   a_inop_eight: assert property (p_inop_eight)
      else $error("ninth rod taken");
   property p_inop_max;
      @(posedge CORE_CLK) disable iff (RST)
         inop_cnt_r <= 7'h36 && $countones(inop_r) == int'(inop_cnt_r);
   endproperty
   a_inop_max: assert property (p_inop_max)
      else $error("inop count bad");
   property p_act_perm;
      @(posedge CORE_CLK) disable iff (RST)
         $changed(act_r) |->
            $past(mode_r) == rbi_pkg::MD_MANUAL && $past(permit_s);
   endproperty
   a_act_perm: assert property (p_act_perm)
      else $error("activation not permitted");
   property p_no_power;
      @(posedge CORE_CLK) disable iff (RST)
         ##1 ((MOTOR_EN | BRAKE_EN) & $past(act_r)) == '0;
   endproperty
   a_no_power: assert property (p_no_power)
      else $error("inop rod powered");
   property p_ovr_pair;
      @(posedge CORE_CLK) disable iff (RST)
         ovr_cnt_r <= 2'h2 && $countones(ovr_r) == int'(ovr_cnt_r);
   endproperty
   a_ovr_pair: assert property (p_ovr_pair)
      else $error("override count bad");
   property p_blk_manual;
      @(posedge CORE_CLK) disable iff (RST)
         blk_eff |=> mode_r != rbi_pkg::MD_AUTO;
   endproperty
   a_blk_manual: assert property (p_blk_manual)
      else $error("auto kept under block");
   property p_scb_mate;
      @(posedge CORE_CLK) disable iff (RST)
         ({scb_r[9], scb_r[7], scb_r[5], scb_r[3], scb_r[1]} &
          {scb_r[8], scb_r[6], scb_r[4], scb_r[2], scb_r[0]}) == 5'h00;
   endproperty
   a_scb_mate: assert property (p_scb_mate)
      else $error("both channels bypassed");
   property p_follow;
      @(posedge CORE_CLK) disable iff (RST)
         tdone_p && ovr_r != '0 |=> (FOLLOW_INS == $past(ovr_r))
            ##1 ((MOTOR_EN & $past(FOLLOW_INS & ~act_r)) ==
                 $past(FOLLOW_INS & ~act_r));
   endproperty
   // inoperable override rods stay unpowered, so only the rest must run
   a_follow: assert property (p_follow)
      else $error("no follow-up insert");
endmodule
`default_nettype wire

// ---- verif/rbi_drive_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// drive-control stand-in: resolver readings and move requests
module rbi_drive_model (
   // clock
   input wire logic clk,
   // bench controls
   input wire logic [5:0] rod_sel,
   input wire logic [63:0] man_i,
   input wire logic [63:0] seq_i,
   // toward the interlock
   output rbi_pkg::rbi_pos_req_t pos_req,
   output logic [63:0] man_req,
   output logic [63:0] seq_req
);
   // resolvers read apart so a wrong pick shows at once
   always_ff @(posedge clk) begin
      pos_req.rod <= rod_sel;
      pos_req.pos_a <= {rod_sel, 10'h2A5};
      pos_req.pos_b <= ~{rod_sel, 10'h2A5};
      man_req <= man_i;
      seq_req <= seq_i;
   end
endmodule
`default_nettype wire

// ---- verif/rod_bypass_interlock_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rod_bypass_interlock_tb;
   typedef struct {int s; logic [63:0] m; logic [63:0] v;} rbi_chk_t;
   localparam logic [1:0] OK = rbi_pkg::RES_OK;
   localparam logic [1:0] REJ = rbi_pkg::RES_REJ;
   logic CORE_CLK = 0;
   logic RST = 1;
   logic HSEL = 0;
   logic HWRITE = 0;
   logic [31:0] HADDR = '0;
   logic [31:0] HWDATA = '0;
   logic [1:0] HTRANS = '0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP;
   logic REFUEL_MODE = 0, BYP_PERMIT = 0, ROD_BLOCK_A = 0, ROD_BLOCK_B = 0;
   logic ALT_ROD_INSERT = 0, SEL_ROD_RUNIN = 0, SCRAM_FOLLOW = 0;
   logic DPS_RUNIN = 0, SCRAM_TEST_DONE = 0;
   logic [5:0] rsel = '0;
   logic [63:0] man = '0, seq = '0, mreq, sreq, MOTOR_EN, BRAKE_EN;
   logic [63:0] FOLLOW_INS, SEQ_CHECK_EN, INOP_TO_PIU, SUBST_MAIN, SUBST_PIU;
   logic [15:0] POS_CH_A, POS_CH_B, pv, pb;
   logic [9:0] SCB_STATE;
   logic [1:0] MODE;
   rbi_pkg::rbi_pos_req_t preq;
   rbi_chk_t q[$];
   logic [63:0] obs [11];
   string nm [11] = '{"hrdata", "motor_en", "brake_en", "follow_ins",
      "seq_check_en", "pos_ch", "inop_to_piu", "subst_piu", "subst_main",
      "mode", "scb_state"};
   int n_fail = 0, comparisons = 0, b, o, k;
   logic dph = 0, look_r = 0;
   logic [63:0] inop, ovr;

   always #5 CORE_CLK = ~CORE_CLK;

   rbi_drive_model u_drv (.clk(CORE_CLK), .rod_sel(rsel), .man_i(man),
      .seq_i(seq), .pos_req(preq), .man_req(mreq), .seq_req(sreq));

   rbi_top u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REFUEL_MODE(REFUEL_MODE),
      .BYP_PERMIT(BYP_PERMIT), .ROD_BLOCK_A(ROD_BLOCK_A),
      .ROD_BLOCK_B(ROD_BLOCK_B), .ALT_ROD_INSERT(ALT_ROD_INSERT),
      .SEL_ROD_RUNIN(SEL_ROD_RUNIN), .SCRAM_FOLLOW(SCRAM_FOLLOW),
      .DPS_RUNIN(DPS_RUNIN), .SCRAM_TEST_DONE(SCRAM_TEST_DONE),
      .MAN_MOVE_REQ(mreq), .SEQ_MOVE_REQ(sreq), .POS_REQ(preq),
      .MOTOR_EN(MOTOR_EN), .BRAKE_EN(BRAKE_EN), .FOLLOW_INS(FOLLOW_INS),
      .SEQ_CHECK_EN(SEQ_CHECK_EN), .POS_CH_A(POS_CH_A),
      .POS_CH_B(POS_CH_B), .INOP_TO_PIU(INOP_TO_PIU),
      .SUBST_MAIN(SUBST_MAIN), .SUBST_PIU(SUBST_PIU),
      .SCB_STATE(SCB_STATE), .MODE(MODE));

   // everything the monitor may compare, widened to one size
   always_comb obs = '{{32'h0, HRDATA}, MOTOR_EN, BRAKE_EN, FOLLOW_INS,
      SEQ_CHECK_EN, {32'h0, POS_CH_A, POS_CH_B}, INOP_TO_PIU, SUBST_PIU,
      SUBST_MAIN, {62'h0, MODE}, {52'h0, HREADYOUT, HRESP, SCB_STATE}};

   // monitor: oldest note against read data or a requested look
   always @(posedge CORE_CLK) begin
      rbi_chk_t c;
      if (dph || look_r) begin
         c = q.pop_front();
         comparisons++;
         if ((obs[c.s] & c.m) !== (c.v & c.m)) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm[c.s], c.v & c.m,
               obs[c.s] & c.m);
         end
      end
      dph <= HSEL & HTRANS[1] & ~HWRITE & HREADYOUT;
   end

   // single ahb-lite transfer, held until hready is seen high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HADDR <= {24'h0, a};
      HTRANS <= 2'h2;
      HWRITE <= w;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
   endtask

   task rd(input logic [7:0] a, input logic [63:0] m, v);
      q.push_back('{0, m, v});
      bus(1'b0, a, 32'h0);
   endtask

   // two idle cycles let the command settle before its result is read
   task cmd(input rbi_pkg::rbi_op_t op, input int r, input logic [15:0] v,
      input logic [1:0] res);
      bus(1'b1, rbi_pkg::A_CMD, {v, 6'h0, 6'(r), op});
      repeat (2) @(posedge CORE_CLK);
      rd(rbi_pkg::A_STAT, 64'h3, {62'h0, res});
   endtask

   // five edges cover pin sync plus output register
   task look(input int s, input logic [63:0] m, v);
      repeat (5) @(posedge CORE_CLK);
      q.push_back('{s, m, v});
      look_r <= 1'b1;
      @(posedge CORE_CLK);
      look_r <= 1'b0;
   endtask

   task finish_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // watchdog, far beyond the fewer than seven hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge CORE_CLK);
      n_fail++;
      finish_test();
   end

   // main sequence
   initial begin
      void'($urandom(32'hfc9a));
      b = 2 * ($urandom % 20);
      pv = 16'($urandom);
      repeat (12) @(posedge CORE_CLK);
      RST <= 1'b0;
      look(4, '1, '1);
      look(9, 64'h3, 64'h0);
      for (k = 0; k < 9; k++) begin
         cmd(rbi_pkg::OP_INOP_SET, b + k, 16'h0,
            (k < 8) ? OK : REJ);
      end
      rd(rbi_pkg::A_STAT, 64'h7F0, 64'h80);
      cmd(rbi_pkg::OP_SUBST, b, pv, OK);
      cmd(rbi_pkg::OP_ACTIVATE, 0, 16'h0, REJ);
      BYP_PERMIT <= 1'b1;
      bus(1'b1, rbi_pkg::A_CTRL, 32'h1);
      cmd(rbi_pkg::OP_ACTIVATE, 0, 16'h0, REJ);
      bus(1'b1, rbi_pkg::A_CTRL, 32'h0);
      cmd(rbi_pkg::OP_ACTIVATE, 0, 16'h0, OK);
      inop = 64'hFF << b;
      look(6, '1, inop);
      look(7, '1, 64'h1 << b);
      look(8, '1, 64'h1 << b);
      rsel <= 6'(b);
      look(5, '1, {32'h0, pv, pv});
      man <= '1;
      look(1, '1, ~inop);
      look(2, '1, ~inop);
      man <= '0;
      rsel <= 6'(b + 10);
      pb = ~{6'(b + 10), 10'h2A5};
      cmd(rbi_pkg::OP_RESA, b + 10, 16'h0, OK);
      cmd(rbi_pkg::OP_RESB, b + 10, 16'h0, REJ);
      look(5, '1, {32'h0, pb, pb});
      // override pair shares one hydraulic unit, next pair is another
      o = b + 12;
      ovr = 64'h3 << o;
      cmd(rbi_pkg::OP_OVR_SET, o, 16'h0, OK);
      cmd(rbi_pkg::OP_OVR_SET, o + 2, 16'h0, REJ);
      cmd(rbi_pkg::OP_OVR_SET, o + 1, 16'h0, OK);
      rd(rbi_pkg::A_OVR_LO, '1, {32'h0, ovr[31:0]});
      rd(rbi_pkg::A_OVR_HI, '1, {32'h0, ovr[63:32]});
      look(4, '1, ~ovr);
      seq <= '1;
      bus(1'b1, rbi_pkg::A_CTRL, 32'h1);
      look(1, '1, ~inop & ~ovr);
      seq <= '0;
      for (k = 0; k < 5; k++) begin
         cmd(rbi_pkg::OP_SCB_SET, 2 * k, 16'h0, OK);
         cmd(rbi_pkg::OP_SCB_SET, 2 * k + 1, 16'h0, REJ);
      end
      cmd(rbi_pkg::OP_SCB_SET, 10, 16'h0, REJ);
      rd(rbi_pkg::A_SCB, '1, 64'h155);
      look(10, '1, {52'h0, 2'b10, 10'h155});
      // each special insertion alone, with every A channel bypassed
      for (k = 0; k < 4; k++) begin
         {ALT_ROD_INSERT, SEL_ROD_RUNIN, SCRAM_FOLLOW, DPS_RUNIN} <= 4'h1 << k;
         look(1, '1, ~inop);
      end
      {ALT_ROD_INSERT, SEL_ROD_RUNIN, SCRAM_FOLLOW, DPS_RUNIN} <= 4'h0;
      SCRAM_TEST_DONE <= 1'b1;
      look(3, '1, ovr);
      SCRAM_TEST_DONE <= 1'b0;
      bus(1'b1, rbi_pkg::A_CTRL, 32'h3);
      look(9, 64'h3, 64'h3);
      ROD_BLOCK_A <= 1'b1;
      look(9, 64'h3, 64'h3);
      ROD_BLOCK_B <= 1'b1;
      look(9, 64'h3, 64'h0);
      REFUEL_MODE <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      for (k = 0; k < 47; k++) begin
         cmd(rbi_pkg::OP_INOP_SET, (b + 8 + k) % 64, 16'h0,
            (k < 46) ? OK : REJ);
      end
      rd(rbi_pkg::A_STAT, 64'h7F0, 64'h360);
      // clears: follow-up drops with its override, substitution with inop
      cmd(rbi_pkg::OP_OVR_CLR, o, 16'h0, OK);
      look(3, '1, ovr & ~(64'h1 << o));
      cmd(rbi_pkg::OP_INOP_CLR, b, 16'h0, OK);
      cmd(rbi_pkg::OP_SUBST, b, pv, REJ);
      cmd(rbi_pkg::OP_SUBST_CLR, b, 16'h0, OK);
      look(7, '1, 64'h0);
      cmd(rbi_pkg::OP_RES_CLR, b + 10, 16'h0, OK);
      cmd(rbi_pkg::OP_RESB, b + 10, 16'h0, OK);
      cmd(rbi_pkg::OP_SCB_CLR, 0, 16'h0, OK);
      cmd(rbi_pkg::OP_SCB_SET, 1, 16'h0, OK);
      look(10, '1, {52'h0, 2'b10, 10'h156});
      cmd(rbi_pkg::OP_NONE, 0, 16'h0, REJ);
      // unmapped address reads back zero
      rd(8'hFC, '1, 64'h0);
      finish_test();
   end
endmodule
`default_nettype wire
